// ### include/irq_front_defs.vh
// constants for the interrupt input front end
// assumes inclusion by bare name from core files
`ifndef IRQ_FRONT_DEFS_VH
`define IRQ_FRONT_DEFS_VH

// ****************************************
// interrupt id map
// ****************************************
`define SHARED_ID_BASE 32
`define PRIVATE_ID_BASE 16
`define PRIVATE_PER_CORE 16
`define SHARED_WIDTH_DEF 32
`define CORES_DEF 4
`define ID_WIDTH 10

// ****************************************
// trigger mode encoding
// ****************************************
`define MODE_LEVEL 1'b0
`define MODE_EDGE 1'b1

// ****************************************
// line history reset values
// ****************************************
// private lines idle high, shared lines idle low
`define SHARED_PREV_RESET 1'b0
`define PRIVATE_PREV_RESET 1'b1

`endif

// ### core/irq_input_front_end.v
// interrupt input front end: shared and private line capture
// assumes all inputs synchronous to i_mclk; mode bits from config logic
`timescale 1ns/10ps
`include "irq_front_defs.vh"

// What this block does
// - Shared line bit k is interrupt id 32 plus k, lowest bit first.
// - Each shared line is an active high level or a rising edge request, per its mode bit.
// - Each private line is an active low level or a rising edge request, per its mode bit.
// - Each private input is a vector with one bit per core, bit n for core n.
// - Sixteen private inputs per core carry fixed ids 16 to 31.
module irq_input_front_end #(
  parameter SHARED_WIDTH = `SHARED_WIDTH_DEF,
  parameter CORES = `CORES_DEF
)
(
  // clock and reset
  input wire i_mclk,
  input wire i_srst,
  // shared lines and modes, bit k is id 32+k
  input wire [SHARED_WIDTH-1:0] i_shared_irq,
  input wire [SHARED_WIDTH-1:0] i_shared_edge_mode,
  input wire [SHARED_WIDTH-1:0] i_shared_ack,
  // private lines, id 16..31, one bit per core
  input wire [CORES-1:0] i_private_irq_id16_per_core,
  input wire [CORES-1:0] i_private_irq_id17,
  input wire [CORES-1:0] i_private_irq_id18,
  input wire [CORES-1:0] i_private_irq_id19,
  input wire [CORES-1:0] i_private_irq_id20,
  input wire [CORES-1:0] i_private_irq_id21,
  input wire [CORES-1:0] i_private_irq_id22,
  input wire [CORES-1:0] i_private_irq_id23,
  input wire [CORES-1:0] i_private_irq_id24,
  input wire [CORES-1:0] i_private_irq_id25,
  input wire [CORES-1:0] i_private_irq_id26,
  input wire [CORES-1:0] i_private_irq_id27,
  input wire [CORES-1:0] i_private_irq_id28,
  input wire [CORES-1:0] i_private_irq_id29,
  input wire [CORES-1:0] i_private_irq_id30,
  input wire [CORES-1:0] i_private_irq_id31_per_core,
  // private modes and acks, index core*16 + (id-16)
  input wire [CORES*16-1:0] i_private_edge_mode,
  input wire [CORES*16-1:0] i_private_ack,
  // request outputs
  output reg [SHARED_WIDTH-1:0] o_shared_pending,
  output reg [CORES*16-1:0] o_private_pending,
  output reg o_any_pending
);

  // ****************************************
  // id helpers
  // ****************************************
  // bit position of a shared id; id 32 sits in bit 0
  function integer shared_bit;
    input integer id;
    begin
      shared_bit = id - `SHARED_ID_BASE;
    end
  endfunction

  // flat position of a private id for one core
  function integer private_bit;
    input integer core;
    input integer id;
    begin
      private_bit = core * `PRIVATE_PER_CORE + id - `PRIVATE_ID_BASE;
    end
  endfunction

  // edge lines report their latch, level lines their request
  function pick_pending;
    input edge_mode;
    input edge_latch;
    input level_req;
    begin
      if (edge_mode == `MODE_EDGE)
        pick_pending = edge_latch;
      else
        pick_pending = level_req;
    end
  endfunction

  // ****************************************
  // private line gathering
  // ****************************************
  reg [CORES*16-1:0] private_raw;
  integer c;
  always @*
  begin
    private_raw = {CORES*16{1'b0}};
    for (c = 0; c < CORES; c = c + 1)
    begin
      // core c owns bit c of every private vector
      // slot j of a core holds id 16 plus j, fixed by wiring
      private_raw[c*16+0] = i_private_irq_id16_per_core[c];
      private_raw[c*16+1] = i_private_irq_id17[c];
      private_raw[c*16+2] = i_private_irq_id18[c];
      private_raw[c*16+3] = i_private_irq_id19[c];
      private_raw[c*16+4] = i_private_irq_id20[c];
      private_raw[c*16+5] = i_private_irq_id21[c];
      private_raw[c*16+6] = i_private_irq_id22[c];
      private_raw[c*16+7] = i_private_irq_id23[c];
      private_raw[c*16+8] = i_private_irq_id24[c];
      private_raw[c*16+9] = i_private_irq_id25[c];
      private_raw[c*16+10] = i_private_irq_id26[c];
      private_raw[c*16+11] = i_private_irq_id27[c];
      private_raw[c*16+12] = i_private_irq_id28[c];
      private_raw[c*16+13] = i_private_irq_id29[c];
      private_raw[c*16+14] = i_private_irq_id30[c];
      private_raw[c*16+15] = i_private_irq_id31_per_core[c];
    end
  end

  // ****************************************
  // edge capture and pending
  // ****************************************
  // no synchroniser here: inputs used directly as sampled
  reg [SHARED_WIDTH-1:0] shared_prev;
  reg [CORES*16-1:0] private_prev;
  reg [SHARED_WIDTH-1:0] shared_latch;
  reg [CORES*16-1:0] private_latch;
  reg [SHARED_WIDTH-1:0] next_shared_pending;
  reg [CORES*16-1:0] next_private_pending;
  wire [SHARED_WIDTH-1:0] shared_rise;
  wire [CORES*16-1:0] private_rise;
  wire [SHARED_WIDTH-1:0] next_shared_latch;
  wire [CORES*16-1:0] next_private_latch;
  reg next_any_pending;
  integer k;
  integer core_n;
  integer id_n;

  assign shared_rise = i_shared_irq & ~shared_prev;
  assign private_rise = private_raw & ~private_prev;
  // a rise in the ack cycle wins over the clear
  assign next_shared_latch = (shared_latch & ~i_shared_ack) | shared_rise;
  assign next_private_latch = (private_latch & ~i_private_ack) | private_rise;

  // ****************************************
  // pending select
  // ****************************************
  // one select for both groups; private level lines are fed to it inverted, as active low
  always @*
  begin
    next_shared_pending = {SHARED_WIDTH{1'b0}};
    next_private_pending = {CORES*16{1'b0}};
    for (k = `SHARED_ID_BASE; k < `SHARED_ID_BASE + SHARED_WIDTH; k = k + 1)
    begin
      next_shared_pending[shared_bit(k)] = pick_pending(i_shared_edge_mode[shared_bit(k)],
        next_shared_latch[shared_bit(k)], i_shared_irq[shared_bit(k)]);
    end
    for (core_n = 0; core_n < CORES; core_n = core_n + 1)
    begin
      for (id_n = `PRIVATE_ID_BASE; id_n < `PRIVATE_ID_BASE + `PRIVATE_PER_CORE; id_n = id_n + 1)
      begin
        // active low level: a low line is a request
        next_private_pending[private_bit(core_n, id_n)] =
          pick_pending(i_private_edge_mode[private_bit(core_n, id_n)],
          next_private_latch[private_bit(core_n, id_n)],
          ~private_raw[private_bit(core_n, id_n)]);
      end
    end
    next_any_pending = (|next_shared_pending) | (|next_private_pending);
  end

  // ****************************************
  // previous samples
  // ****************************************
  // history resets to the idle level of each group so reset gives no false rise
  always @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      shared_prev <= {SHARED_WIDTH{`SHARED_PREV_RESET}};
      private_prev <= {CORES*16{`PRIVATE_PREV_RESET}};
    end
    else
    begin
      shared_prev <= i_shared_irq;
      private_prev <= private_raw;
    end
  end

  // ****************************************
  // edge latches
  // ****************************************
  // level lines keep latches clear so a mode switch starts clean
  always @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      shared_latch <= {SHARED_WIDTH{1'b0}};
      private_latch <= {CORES*16{1'b0}};
    end
    else
    begin
      shared_latch <= next_shared_latch & i_shared_edge_mode;
      private_latch <= next_private_latch & i_private_edge_mode;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  // one cycle of latency buys outputs straight from flops
  always @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      o_shared_pending <= {SHARED_WIDTH{1'b0}};
      o_private_pending <= {CORES*16{1'b0}};
      o_any_pending <= 1'b0;
    end
    else
    begin
      o_shared_pending <= next_shared_pending;
      o_private_pending <= next_private_pending;
      o_any_pending <= next_any_pending;
    end
  end

endmodule

// ### verification/irq_src_model.sv
// peripheral model: fans flat private lines out to per-id core vectors
// assumes the bench changes i_lines just after a falling edge
`timescale 1ns/10ps
module irq_src_model (
  // flat lines, index core*16+(id-16)
  input wire logic [63:0] i_lines,
  // per-id vectors, bit n is core n
  output logic [15:0][3:0] o_pid
);
  // lines only move with the bench's falling edge stimulus
  // timers sit on 30 29 27 26, other local sources on 25 down to 22
  always_comb
  begin
    for (int i = 0; i < 64; i++)
      o_pid[i%16][i/16] = i_lines[i];
  end
endmodule

// ### verification/irq_front_props.sv
// checker on the front end ports
// assumes bind onto the front end top
`timescale 1ns/10ps
module irq_front_props #(parameter SHARED_WIDTH = 32, parameter CORES = 4) (
  input wire i_mclk, i_srst,
  input wire [SHARED_WIDTH-1:0] i_shared_irq, i_shared_edge_mode, i_shared_ack,
  input wire [CORES-1:0] i_private_irq_id16_per_core,
  input wire [CORES*16-1:0] i_private_edge_mode, o_private_pending,
  input wire [SHARED_WIDTH-1:0] o_shared_pending
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  a_shared_level_map: assert property (1 |=>
    ((o_shared_pending ^ $past(i_shared_irq)) & ~$past(i_shared_edge_mode)) == 0)
    else $error("shared level pending wrong");
  a_priv_level_inv: assert property (!i_private_edge_mode[16] |=>
    o_private_pending[16] == !$past(i_private_irq_id16_per_core[1]))
    else $error("private level");
  a_shared_rise_set: assert property (i_shared_edge_mode[0] && !$past(i_srst) &&
    i_shared_irq[0] && !$past(i_shared_irq[0]) |=> o_shared_pending[0]) else $error("no latch");
  a_shared_edge_hold: assert property (i_shared_edge_mode[0] &&
    $past(i_shared_edge_mode[0]) && o_shared_pending[0] && !i_shared_ack[0] |=>
    o_shared_pending[0]) else $error("lost");
  a_shared_ack_clear: assert property (i_shared_edge_mode[0] && i_shared_ack[0] &&
    !$past(i_srst) && !$rose(i_shared_irq[0]) |=> !o_shared_pending[0]) else $error("ack");
  a_priv_rise_set: assert property (i_private_edge_mode[0] && !$past(i_srst) &&
    $rose(i_private_irq_id16_per_core[0]) |=> o_private_pending[0]) else $error("no rise");
endmodule

// ### verification/irq_input_front_end_tb.sv
// bench: random lines, modes and acks against a reference of the pending logic
// assumes default widths, 32 shared lines and 4 cores
`timescale 1ns/10ps
module irq_input_front_end_tb;
  logic i_mclk = 0, i_srst = 1;
  logic [95:0] line = 0, mode = 0, ack = 0, prev, lat, e;
  logic [31:0] seed = 32'hf8fc_7ef1;
  logic [96:0] q[$];
  int bad_count = 0, n_compared = 0;
  wire [31:0] sp;
  wire [63:0] pp;
  wire any;
  wire [15:0][3:0] pid;
  irq_src_model u_src (.i_lines(line[95:32]), .o_pid(pid));
  irq_input_front_end u_dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_shared_irq(line[31:0]),
    .i_shared_edge_mode(mode[31:0]), .i_shared_ack(ack[31:0]),
    .i_private_irq_id16_per_core(pid[0]), .i_private_irq_id17(pid[1]),
    .i_private_irq_id18(pid[2]), .i_private_irq_id19(pid[3]), .i_private_irq_id20(pid[4]),
    .i_private_irq_id21(pid[5]), .i_private_irq_id22(pid[6]), .i_private_irq_id23(pid[7]),
    .i_private_irq_id24(pid[8]), .i_private_irq_id25(pid[9]), .i_private_irq_id26(pid[10]),
    .i_private_irq_id27(pid[11]), .i_private_irq_id28(pid[12]), .i_private_irq_id29(pid[13]),
    .i_private_irq_id30(pid[14]), .i_private_irq_id31_per_core(pid[15]),
    .i_private_edge_mode(mode[95:32]), .i_private_ack(ack[95:32]),
    .o_shared_pending(sp), .o_private_pending(pp), .o_any_pending(any));
  function automatic logic [31:0] rnd();
    seed = seed[0] ? (seed >> 1) ^ 32'h8020_0003 : seed >> 1;
    return seed;
  endfunction
  task automatic check(input logic [96:0] seen, input logic [96:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: pending %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial forever #25 i_mclk = ~i_mclk;
  // phases: all level, all edge, then two mixed; each opens with a reset
  initial
  begin
    for (int ph = 0; ph < 4; ph++)
    begin
      i_srst = 1;
      prev = {{64{1'b1}}, 32'h0000_0000};
      lat = 0;
      repeat (8) @(negedge i_mclk);
      i_srst = 0;
      mode = ph == 0 ? 96'h0 : ph == 1 ? '1 : {rnd(), rnd(), rnd()};
      for (int n = 0; n < 250; n++)
      begin
        // mixed phases also swap modes mid-run so a switch meets a live latch
        if (ph > 1 && n % 50 == 49)
          mode = {rnd(), rnd(), rnd()};
        line = {rnd(), rnd(), rnd()};
        ack = {rnd(), rnd(), rnd()} & {rnd(), rnd(), rnd()};
        lat = mode & (line & ~prev | lat & ~ack);
        e = mode & lat | ~mode & (line ^ {{64{1'b1}}, 32'h0000_0000});
        prev = line;
        q.push_back({|e, e});
        @(negedge i_mclk);
      end
    end
    @(negedge i_mclk);
    results();
  end
  always @(posedge i_mclk)
    if (q.size() > 0)
    begin
      #1 check({any, pp, sp}, q.pop_front());
    end
  // hang guard, about twice the expected run
  initial
  begin
    repeat (2000) @(posedge i_mclk);
    bad_count++;
    results();
  end
endmodule
bind irq_input_front_end irq_front_props #(.SHARED_WIDTH(SHARED_WIDTH), .CORES(CORES)) u_props (.*);
